// ==== design/ssr_top.sv ====
// serial port status, interrupt flags, dma requests and data window over apb
// assumes a clean apb master on i_clock and serial pins from outside the domain
//
// Summary of operation
// - status bit 4 rx full, bit 3 rx not empty, bit 6 collision
// - status bit 2 tx empty, bit 1 tx not full, bit 0 busy, bit 5 error
// - six-bit read-write interrupt mask, one bit per source
// - raw interrupt bits show each condition regardless of mask
// - masked interrupt bits are raw bits anded with mask
// - reading tx overflow ack clears it, returns it in bit 0
// - reading rx overflow ack clears it, returns it in bit 0
// - reading rx underflow ack clears it, returns it in bit 0
// - reading contention ack clears it, returns it in bit 0
// - reading global ack clears all, bit 0 says any was active
// - tx dma request only when enabled, against eight-bit watermark
// - rx dma request only when enabled, watermark plus one entry
// - rx data sampled later by delay field serial clocks, reset zero
// - 36-word data window from 0x60 onto one data path
// - read-only version and identification words
// - tx empty condition uses eight-bit tx threshold
// - rx full condition uses eight-bit rx threshold
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`include "ssr_consts.svh"
module ssr_top
    import ssr_pkg::*;
#(
    parameter ssr_word_t ID_VALUE      = 32'h0000_0001, // arbitrary value
    parameter ssr_word_t VERSION_VALUE = 32'h0000_0001  // arbitrary value
)(
    input  wire logic        i_clock,
    input  wire logic        i_arst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_sclk,
    input  wire logic        i_rxd,
    input  wire logic        i_contention,
    output logic             o_txd,
    output logic             o_tx_dma_req,
    output logic             o_rx_dma_req
);
    logic [2:0]  pin_in;
    logic [2:0]  pin_q;
    logic        sclk_prev;
    logic        sclk_rise;
    ssr_word_t   tx_mem [8];
    ssr_word_t   rx_mem [8];
    logic [2:0]  tx_wp;
    logic [2:0]  tx_rp;
    logic [2:0]  rx_wp;
    logic [2:0]  rx_rp;
    logic [3:0]  tx_cnt;
    logic [3:0]  rx_cnt;
    logic        tx_full;
    logic        rx_full;
    logic        tx_push;
    logic        tx_pop;
    logic        rx_push;
    logic        rx_pop;
    ssr_word_t   rx_word;
    ssr_state_t  state;
    logic [8:0]  bitcnt;
    logic [8:0]  last_cnt;
    ssr_word_t   tx_sh;
    ssr_word_t   rx_sh;
    logic        done;
    logic [5:0]  imask;
    logic [5:0]  raw;
    logic [1:0]  dma_en;
    logic [7:0]  tx_wm;
    logic [7:0]  rx_wm;
    logic [7:0]  tx_thr;
    logic [7:0]  rx_thr;
    logic [7:0]  dly;
    logic        txo;
    logic        rxo;
    logic        rxu;
    logic        mst;
    logic        mst_prev;
    logic        setup;
    logic        acc;
    logic        rd_acc;
    logic        wr_acc;
    logic        win;
    logic        hit;
    logic        err_q;
    logic        rd_empty_q;
    ssr_word_t   rd_mux;
    logic [6:0]  status;

    // three-stage synchronisers; a change counts once stages two and three agree
    assign pin_in = {i_contention, i_rxd, i_sclk};
    for (genvar g = 0; g < 3; g++)
    begin : g_sync
        logic [2:0] s;
        always_ff @(posedge i_clock or negedge i_arst_n)
        begin
            if (!i_arst_n)
            begin
                s <= 3'h0;
                pin_q[g] <= 1'b0;
            end
            else
            begin
                s <= {s[1:0], pin_in[g]};
                if (s[1] == s[2])
                    pin_q[g] <= s[2];
            end
        end
    end

    // serial clock edge finder, contention edge history
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            sclk_prev <= 1'b0;
            mst_prev <= 1'b0;
        end
        else
        begin
            sclk_prev <= pin_q[0];
            mst_prev <= pin_q[2];
        end
    end
    assign sclk_rise = pin_q[0] & ~sclk_prev;

    // apb decode; zero wait states, read data captured in the setup cycle
    assign setup = i_psel & ~i_penable;
    assign acc = i_psel & i_penable;
    assign rd_acc = acc & ~i_pwrite;
    assign wr_acc = acc & i_pwrite;
    assign win = (i_paddr >= `SSR_A_WIN_LO) && (i_paddr <= `SSR_A_WIN_HI)
               && (i_paddr[1:0] == 2'h0);
    assign o_pready = 1'b1;
    assign o_pslverr = acc & err_q;

    // queue flags and pushes; window write goes to tx, window read pops rx
    assign tx_full = (tx_cnt == `SSR_DEPTH);
    assign rx_full = (rx_cnt == `SSR_DEPTH);
    assign tx_push = wr_acc & win & ~tx_full;
    assign rx_pop = rd_acc & win & ~rd_empty_q;
    assign tx_pop = (state == ssr_idle) && (tx_cnt != `SSR_CNT_ZERO);
    assign rx_word = {rx_sh[30:0], pin_q[1]};
    assign rx_push = done & ~rx_full;

    // queue storage without reset; contents are only read behind the counts
    always_ff @(posedge i_clock)
    begin
        if (tx_push)
            tx_mem[tx_wp] <= i_pwdata;
        if (rx_push)
            rx_mem[rx_wp] <= rx_word;
    end

    // queue pointers and counts
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            tx_wp <= 3'h0;
            tx_rp <= 3'h0;
            rx_wp <= 3'h0;
            rx_rp <= 3'h0;
            tx_cnt <= `SSR_CNT_ZERO;
            rx_cnt <= `SSR_CNT_ZERO;
        end
        else
        begin
            if (tx_push)
                tx_wp <= tx_wp + `SSR_ONE3;
            if (tx_pop)
                tx_rp <= tx_rp + `SSR_ONE3;
            if (rx_push)
                rx_wp <= rx_wp + `SSR_ONE3;
            if (rx_pop)
                rx_rp <= rx_rp + `SSR_ONE3;
            tx_cnt <= tx_cnt + {3'h0, tx_push} - {3'h0, tx_pop};
            rx_cnt <= rx_cnt + {3'h0, rx_push} - {3'h0, rx_pop};
        end
    end

    // shift engine: 32 bits out, rx taken dly serial clocks late
    assign last_cnt = {1'b0, dly} + `SSR_LAST_BIT;
    assign done = (state == ssr_shift) && sclk_rise && (bitcnt == last_cnt);
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state <= ssr_idle;
            bitcnt <= 9'h000;
            tx_sh <= `SSR_RST32;
            rx_sh <= `SSR_RST32;
        end
        else
        begin
            case (state)
                ssr_idle:
                begin
                    if (tx_pop)
                    begin
                        state <= ssr_shift;
                        bitcnt <= 9'h000;
                        tx_sh <= tx_mem[tx_rp];
                    end
                end
                ssr_shift:
                begin
                    if (sclk_rise)
                    begin
                        bitcnt <= bitcnt + 9'h001;
                        if (bitcnt < `SSR_LAST_BIT)
                            tx_sh <= {tx_sh[30:0], 1'b0};
                        if (bitcnt >= {1'b0, dly})
                            rx_sh <= rx_word;
                        if (done)
                            state <= ssr_idle;
                    end
                end
                default:
                    state <= ssr_idle;
            endcase
        end
    end
    assign o_txd = tx_sh[31];

    // sticky event flags; an event in the clearing cycle wins over the clear
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            txo <= 1'b0;
            rxo <= 1'b0;
            rxu <= 1'b0;
            mst <= 1'b0;
        end
        else
        begin
            txo <= (txo & ~(rd_acc && (i_paddr == `SSR_A_TXO_ACK || i_paddr == `SSR_A_ALL_ACK)))
                 | (wr_acc & win & tx_full);
            rxo <= (rxo & ~(rd_acc && (i_paddr == `SSR_A_RXO_ACK || i_paddr == `SSR_A_ALL_ACK)))
                 | (done & rx_full);
            rxu <= (rxu & ~(rd_acc && (i_paddr == `SSR_A_RXU_ACK || i_paddr == `SSR_A_ALL_ACK)))
                 | (rd_acc & win & rd_empty_q);
            mst <= (mst & ~(rd_acc && (i_paddr == `SSR_A_MST_ACK || i_paddr == `SSR_A_ALL_ACK)))
                 | (pin_q[2] & ~mst_prev);
        end
    end

    // raw sources; level conditions follow the queue counts directly
    assign raw[`SSR_IRQ_TXE] = {4'h0, tx_cnt} <= tx_thr;
    assign raw[`SSR_IRQ_TXO] = txo;
    assign raw[`SSR_IRQ_RXU] = rxu;
    assign raw[`SSR_IRQ_RXO] = rxo;
    assign raw[`SSR_IRQ_RXF] = {4'h0, rx_cnt} > rx_thr;
    assign raw[`SSR_IRQ_MST] = mst;

    // status word; error flags mirror the sticky tx overflow and contention events
    assign status = {mst, txo, rx_full, rx_cnt != `SSR_CNT_ZERO,
                     tx_cnt == `SSR_CNT_ZERO, ~tx_full, state == ssr_shift};

    // dma requests, combinational from counts so they drop as soon as served
    assign o_tx_dma_req = dma_en[`SSR_DMA_TX] & ({4'h0, tx_cnt} <= tx_wm);
    assign o_rx_dma_req = dma_en[`SSR_DMA_RX] & ({4'h0, rx_cnt} > rx_wm);

    // writable control registers
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            imask <= `SSR_RST6;
            dma_en <= 2'h0;
            tx_wm <= `SSR_RST8;
            rx_wm <= `SSR_RST8;
            tx_thr <= `SSR_RST8;
            rx_thr <= `SSR_RST8;
            dly <= `SSR_RST8;
        end
        else if (wr_acc)
        begin
            case (i_paddr)
                `SSR_A_IMASK:  imask <= i_pwdata[5:0];
                `SSR_A_DMA_EN: dma_en <= i_pwdata[1:0];
                `SSR_A_TX_WM:  tx_wm <= i_pwdata[7:0];
                `SSR_A_RX_WM:  rx_wm <= i_pwdata[7:0];
                `SSR_A_TX_THR: tx_thr <= i_pwdata[7:0];
                `SSR_A_RX_THR: rx_thr <= i_pwdata[7:0];
                `SSR_A_DELAY:  dly <= i_pwdata[7:0];
                default:       dly <= dly;
            endcase
        end
    end

    // read mux; unmapped offsets read zero and flag an error
    always_comb
    begin
        rd_mux = `SSR_RST32;
        hit = 1'b1;
        case (i_paddr)
            `SSR_A_TX_THR:   rd_mux[7:0] = tx_thr;
            `SSR_A_RX_THR:   rd_mux[7:0] = rx_thr;
            `SSR_A_TX_LEVEL: rd_mux[3:0] = tx_cnt;
            `SSR_A_RX_LEVEL: rd_mux[3:0] = rx_cnt;
            `SSR_A_STATUS:   rd_mux[6:0] = status;
            `SSR_A_IMASK:    rd_mux[5:0] = imask;
            `SSR_A_IMSTAT:   rd_mux[5:0] = raw & imask;
            `SSR_A_IRAW:     rd_mux[5:0] = raw;
            `SSR_A_TXO_ACK:  rd_mux[0] = txo;
            `SSR_A_RXO_ACK:  rd_mux[0] = rxo;
            `SSR_A_RXU_ACK:  rd_mux[0] = rxu;
            `SSR_A_MST_ACK:  rd_mux[0] = mst;
            `SSR_A_ALL_ACK:  rd_mux[0] = txo | rxo | rxu | mst;
            `SSR_A_DMA_EN:   rd_mux[1:0] = dma_en;
            `SSR_A_TX_WM:    rd_mux[7:0] = tx_wm;
            `SSR_A_RX_WM:    rd_mux[7:0] = rx_wm;
            `SSR_A_IDENT:    rd_mux = ID_VALUE;
            `SSR_A_VERSION:  rd_mux = VERSION_VALUE;
            `SSR_A_DELAY:    rd_mux[7:0] = dly;
            default:
            begin
                if (win)
                    rd_mux = rx_mem[rx_rp];
                else
                    hit = 1'b0;
            end
        endcase
    end

    // capture read data and decode in setup; pops happen at the access edge
    always_ff @(posedge i_clock or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_prdata <= `SSR_RST32;
            err_q <= 1'b0;
            rd_empty_q <= 1'b0;
        end
        else if (setup)
        begin
            o_prdata <= (win && rx_cnt == `SSR_CNT_ZERO) ? `SSR_RST32 : rd_mux;
            err_q <= ~hit;
            rd_empty_q <= (rx_cnt == `SSR_CNT_ZERO);
        end
    end

    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_arst_n);
    sequence s_win_wr_full;
        wr_acc && win && tx_full;
    endsequence
    sequence s_win_rd_empty;
        rd_acc && win && rd_empty_q;
    endsequence
    // a pop may free a slot in the same cycle, so judge the dropped word by the write pointer
    a_tx_over_set: assert property (s_win_wr_full |=> txo && $stable(tx_wp))
        else $error("tx overflow not flagged");
    a_rx_under_set: assert property (s_win_rd_empty |=> rxu && $stable(rx_rp))
        else $error("rx underflow not flagged");
    a_txo_ack_clear: assert property (rd_acc && i_paddr == `SSR_A_TXO_ACK && !(wr_acc && win && tx_full)
        |=> !txo)
        else $error("tx overflow ack did not clear");
    a_all_ack_clear: assert property (rd_acc && i_paddr == `SSR_A_ALL_ACK && !done && !win
        && !(pin_q[2] && !mst_prev) |=> !(txo || rxo || rxu || mst))
        else $error("global ack did not clear");
    a_tx_dma_gate: assert property (!dma_en[`SSR_DMA_TX] |-> !o_tx_dma_req)
        else $error("tx dma request while disabled");
    a_rx_dma_level: assert property (o_rx_dma_req |-> {4'h0, rx_cnt} >= rx_wm + 8'h01)
        else $error("rx dma request below watermark");
    a_rx_level_push: assert property (rx_push && !rx_pop |=> rx_cnt == $past(rx_cnt) + 4'h1)
        else $error("rx level did not count push");
    a_frame_length: assert property (state == ssr_shift && !done |=> state == ssr_shift)
        else $error("frame ended early");
    a_rx_delay_hold: assert property (state == ssr_shift && sclk_rise && bitcnt < {1'b0, dly}
        |=> $stable(rx_sh))
        else $error("rx bit taken inside the sample delay");
    a_mask_write: assert property (wr_acc && i_paddr == `SSR_A_IMASK
        |=> imask == $past(i_pwdata[5:0]))
        else $error("mask write lost");
endmodule

// ==== design/ssr_consts.svh ====
// offsets, field positions and reset values of the serial port registers
// assumes an 8-bit byte address on the register bus, 32-bit aligned words
`ifndef SSR_CONSTS_SVH
`define SSR_CONSTS_SVH
`define SSR_A_TX_THR    8'h18
`define SSR_A_RX_THR    8'h1C
`define SSR_A_TX_LEVEL  8'h20
`define SSR_A_RX_LEVEL  8'h24
`define SSR_A_STATUS    8'h28
`define SSR_A_IMASK     8'h2C
`define SSR_A_IMSTAT    8'h30
`define SSR_A_IRAW      8'h34
`define SSR_A_TXO_ACK   8'h38
`define SSR_A_RXO_ACK   8'h3C
`define SSR_A_RXU_ACK   8'h40
`define SSR_A_MST_ACK   8'h44
`define SSR_A_ALL_ACK   8'h48
`define SSR_A_DMA_EN    8'h4C
`define SSR_A_TX_WM     8'h50
`define SSR_A_RX_WM     8'h54
`define SSR_A_IDENT     8'h58
`define SSR_A_VERSION   8'h5C
`define SSR_A_WIN_LO    8'h60
`define SSR_A_WIN_HI    8'hEC
`define SSR_A_DELAY     8'hF0
`define SSR_IRQ_TXE     0
`define SSR_IRQ_TXO     1
`define SSR_IRQ_RXU     2
`define SSR_IRQ_RXO     3
`define SSR_IRQ_RXF     4
`define SSR_IRQ_MST     5
`define SSR_DMA_RX      0
`define SSR_DMA_TX      1
`define SSR_DEPTH       4'h8
`define SSR_CNT_ZERO    4'h0
`define SSR_ONE3        3'h1
`define SSR_RST8        8'h00
`define SSR_RST6        6'h00
`define SSR_RST32       32'h0000_0000
`define SSR_LAST_BIT    9'h01F
`endif

// ==== design/ssr_pkg.sv ====
// types shared by the serial port status and data register block
// assumes ssr_consts.svh supplies the numeric constants
package ssr_pkg;
    typedef enum logic {ssr_idle, ssr_shift} ssr_state_t;
    typedef logic [31:0] ssr_word_t;
endpackage

// ==== testbench/ssr_spi_peer.sv ====
// serial peripheral model: drives the link clock and receive data, one frame per call
// assumes the bench calls run_frame only while the port holds a word; the clock idles low
`timescale 1ns/1ns
module ssr_spi_peer (
    output logic      o_sclk,
    output logic      o_rxd,
    input  wire logic i_txd
);
    logic [31:0] got;

    // idle levels before the first frame
    initial
    begin
        o_sclk = 1'b0;
        o_rxd  = 1'b0;
        got    = 32'h0;
    end

    // msb first, 320 ns period; the 7 ns offset keeps edges off the system clock edges
    task automatic run_frame(input logic [31:0] word, input int dly);
        int k;
        #7;
        for (k = 0; k < 32 + dly; k++)
        begin
            // junk before the delay runs out, so a wrong delay corrupts the word
            o_rxd = (k >= dly) ? word[31 - (k - dly)] : ~o_rxd;
            #160;
            if (k < 32)
                got = {got[30:0], i_txd};
            o_sclk = 1'b1;
            #160;
            o_sclk = 1'b0;
        end
        o_rxd = ~o_rxd; // released line has no pull: show the inverse
    endtask
endmodule

// ==== testbench/tb_ssr_top.sv ====
// self-checking bench for the serial port register block, apb master tasks
// assumes ssr_top from design/ and the peer model in testbench/
`timescale 1ns/1ns
`include "ssr_consts.svh"
module tb_ssr_top
    import ssr_pkg::*;
;
    localparam ssr_word_t ID_V  = 32'h00C0_FFEE; // arbitrary value
    localparam ssr_word_t VER_V = 32'h0000_0102; // arbitrary value
    logic       clock;
    logic       arst_n;
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    ssr_word_t  pwdata;
    ssr_word_t  prdata;
    logic       pready;
    logic       pslverr;
    logic       sclk;
    logic       rxd;
    logic       contention;
    logic       txd;
    logic       tx_req;
    logic       rx_req;
    int         bad_count = 0;
    int         comparisons = 0;
    ssr_word_t  rd;
    logic       err;
    ssr_word_t  txw [0:9];
    ssr_word_t  rxw [0:8];
    logic [7:0] ra [0:16] = '{8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38,
                              8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C, 8'h50, 8'h54, 8'hF0};

    ssr_top #(.ID_VALUE(ID_V), .VERSION_VALUE(VER_V)) u_ssr_top (
        .i_clock      (clock),
        .i_arst_n     (arst_n),
        .i_psel       (psel),
        .i_penable    (penable),
        .i_pwrite     (pwrite),
        .i_paddr      (paddr),
        .i_pwdata     (pwdata),
        .o_prdata     (prdata),
        .o_pready     (pready),
        .o_pslverr    (pslverr),
        .i_sclk       (sclk),
        .i_rxd        (rxd),
        .i_contention (contention),
        .o_txd        (txd),
        .o_tx_dma_req (tx_req),
        .o_rx_dma_req (rx_req)
    );

    ssr_spi_peer u_ssr_spi_peer (
        .o_sclk (sclk),
        .o_rxd  (rxd),
        .i_txd  (txd)
    );

    // 25 MHz system clock
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic check(input ssr_word_t seen, input ssr_word_t exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one transfer; request held until pready is seen, a hang ends the run
    task automatic apb(input logic wr, input logic [7:0] a, input ssr_word_t wd);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clock);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clock);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            bad_count++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [7:0] a, input ssr_word_t d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input logic [7:0] a, input ssr_word_t exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // contention pulse long enough to pass the input synchroniser
    task automatic bump();
        @(posedge clock) contention <= 1'b1;
        repeat (4) @(posedge clock);
        contention <= 1'b0;
        repeat (6) @(posedge clock);
    endtask

    // main sequence
    initial
    begin
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        contention = 1'b0;
        for (int i = 0; i < 10; i++)
            txw[i] = 32'hA5C3_0F10 + i;
        for (int i = 0; i < 9; i++)
            rxw[i] = 32'h0F1E_2D3C ^ {4{8'(i * 17)}};
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        foreach (ra[i])
            rdchk(ra[i], (ra[i] == 8'h28) ? 32'h6 : (ra[i] == 8'h34) ? 32'h1 : 32'h0);
        rdchk(8'h58, ID_V);
        rdchk(8'h5C, VER_V);
        wr(8'h5C, 32'hFFFF_FFFF);
        rdchk(8'h5C, VER_V);
        $display("reset values done");
        wr(8'h2C, 32'hFFFF_FFFF);
        rdchk(8'h2C, 32'h3F);
        rdchk(8'h30, 32'h1);
        wr(8'h2C, 32'hA);
        rdchk(8'h30, 32'h0);
        wr(8'h28, 32'hFFFF_FFFF);
        rdchk(8'h28, 32'h6);
        apb(1'b0, 8'h00, 32'h0);
        check(ssr_word_t'(err), 32'h1);
        check(rd, 32'h0);
        $display("mask and access done");
        rdchk(8'hEC, 32'h0);
        rdchk(8'h34, 32'h5);
        rdchk(8'h40, 32'h1);
        rdchk(8'h40, 32'h0);
        rdchk(8'h34, 32'h1);
        $display("underflow done");
        wr(8'hF0, 32'h3);
        for (int i = 0; i < 10; i++)
            wr(i[0] ? 8'hEC : 8'h60, txw[i]);
        rdchk(8'h20, 32'h8);
        rdchk(8'h28, 32'h21);
        rdchk(8'h34, 32'h2);
        wr(8'h18, 32'h8);
        rdchk(8'h34, 32'h3);
        rdchk(8'h30, 32'h2);
        wr(8'h50, 32'h8);
        wr(8'h4C, 32'h2);
        #1;
        check(ssr_word_t'(tx_req), 32'h1);
        check(ssr_word_t'(rx_req), 32'h0);
        wr(8'h50, 32'h7);
        #1;
        check(ssr_word_t'(tx_req), 32'h0);
        rdchk(8'h38, 32'h1);
        rdchk(8'h38, 32'h0);
        $display("tx overflow done");
        // queue limited to depth: the tenth word was dropped
        for (int f = 0; f < 9; f++)
        begin
            u_ssr_spi_peer.run_frame(rxw[f], 3);
            repeat (12) @(posedge clock);
            check(u_ssr_spi_peer.got, txw[f]);
        end
        rdchk(8'h24, 32'h8);
        rdchk(8'h28, 32'h1E);
        rdchk(8'h34, 32'h19);
        wr(8'h1C, 32'h8);
        rdchk(8'h34, 32'h9);
        rdchk(8'h30, 32'h8);
        wr(8'h54, 32'h7);
        wr(8'h4C, 32'h3);
        #1;
        check(ssr_word_t'(rx_req), 32'h1);
        check(ssr_word_t'(tx_req), 32'h1);
        wr(8'h54, 32'h8);
        #1;
        check(ssr_word_t'(rx_req), 32'h0);
        rdchk(8'h3C, 32'h1);
        for (int i = 0; i < 8; i++)
            rdchk(i[0] ? 8'hEC : 8'h60, rxw[i]);
        rdchk(8'h28, 32'h6);
        $display("frames done");
        bump();
        rdchk(8'h28, 32'h46);
        rdchk(8'h34, 32'h21);
        rdchk(8'h44, 32'h1);
        rdchk(8'h34, 32'h1);
        bump();
        rdchk(8'h60, 32'h0);
        rdchk(8'h34, 32'h25);
        rdchk(8'h48, 32'h1);
        rdchk(8'h34, 32'h1);
        rdchk(8'h48, 32'h0);
        $display("acknowledge done");
        report_and_stop();
    end
endmodule
